// [verilog/ppk_pkg.sv]
package ppk_pkg;
   // register page offsets
   localparam logic [7:0] PPK_OFF_PORT_A_LATCH = 8'h00;
   localparam logic [7:0] PPK_OFF_PORT_B_LATCH = 8'h01;
   localparam logic [7:0] PPK_OFF_PORT_C_LATCH = 8'h02;
   localparam logic [7:0] PPK_OFF_PORT_D_INPUTS = 8'h03;
   localparam logic [7:0] PPK_OFF_PORT_A_DIRECTION = 8'h04;
   localparam logic [7:0] PPK_OFF_PORT_B_DIRECTION = 8'h05;
   localparam logic [7:0] PPK_OFF_PORT_C_DIRECTION = 8'h06;
   // reset values
   localparam logic [7:0] PPK_RST_DIRECTION = 8'h00;
   localparam logic [7:0] PPK_RST_LATCH = 8'h00;
   // port d: bit 6 absent, serial pin ownership masks
   localparam logic [7:0] PPK_PD_PRESENT_MASK = 8'hBF;
   localparam logic [7:0] PPK_PD_SCI_MASK = 8'h03;
   localparam logic [7:0] PPK_PD_SPI_MASK = 8'h3C;
   localparam int PPK_PD_RXD_BIT = 0;
   localparam int PPK_PD_TXD_BIT = 1;
   localparam int PPK_PD_MISO_BIT = 2;
   localparam int PPK_PD_MOSI_BIT = 3;
   localparam int PPK_PD_SCK_BIT = 4;
   localparam int PPK_PD_SS_BIT = 5;
   // tone pins are port a bits 4..7
   localparam logic [7:0] PPK_TONE_MASK = 8'hF0;
   // default tone divider ratio in system clocks
   localparam int PPK_TONE_DIV_DEFAULT = 1000;
   typedef enum logic [1:0] {
      PPK_IRQ_IDLE = 2'b01,
      PPK_IRQ_ARMED = 2'b10
   } ppk_irq_state_t;
endpackage

// [verilog/ppk_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for a bus of pin levels
module ppk_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule
`default_nettype wire

// [verilog/ppk_ports.sv]
`timescale 1ns/100ps
`default_nettype none
module ppk_ports
   import ppk_pkg::*;
#(
   parameter bit TONE_OPTION = 1'b1,
   parameter bit OPEN_DRAIN_OPTION = 1'b0,
   parameter bit KEYBOARD_OPTION = 1'b1,
   parameter bit LEVEL_SENSE = 1'b0,
   parameter int TONE_DIV = PPK_TONE_DIV_DEFAULT
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // processor register page access
   input wire logic [7:0] cpu_addr_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   input wire logic [7:0] cpu_wdata_i,
   output logic [7:0] cpu_rdata_o,
   // processor interrupt handshake
   input wire logic int_mask_i,
   input wire logic instr_end_i,
   input wire logic int_ack_i,
   output logic ext_int_req_o,
   output logic int_line_high_o,
   // pins
   input wire logic [7:0] port_a_pin_i,
   output logic [7:0] port_a_pin_o,
   output logic [7:0] port_a_pin_oe_n_o,
   input wire logic [7:0] port_b_pin_i,
   output logic [7:0] port_b_pin_o,
   output logic [7:0] port_b_pin_oe_n_o,
   output logic [7:0] port_b_pullup_o,
   input wire logic [7:0] port_c_pin_i,
   output logic [7:0] port_c_pin_o,
   output logic [7:0] port_c_pin_oe_n_o,
   input wire logic [7:0] port_d_pin_i,
   input wire logic irq_pin_n_i,
   // serial interface enables and data
   input wire logic sci_enable_i,
   input wire logic spi_enable_i,
   output logic sci_rx_o,
   output logic spi_miso_o,
   output logic spi_mosi_o,
   output logic spi_sck_o,
   output logic spi_ss_n_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] latch_a_reg, latch_b_reg, latch_c_reg;
   logic [7:0] dir_a_reg, dir_b_reg, dir_c_reg;
   logic [7:0] rdata_reg;
   logic [7:0] sa, sb, sc, sd;
   logic irq_sync;
   logic tone_reg;
   logic [31:0] tone_cnt_reg;
   logic pending_reg;
   ppk_irq_state_t irq_state_reg, irq_state_next;

   ppk_sync #(.WIDTH(33), .INIT('1)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i({irq_pin_n_i, port_d_pin_i, port_c_pin_i, port_b_pin_i, port_a_pin_i}),
      .sync_o({irq_sync, sd, sc, sb, sa})
   );

   ////////////////////////////////////////////////////////////////////////
   // register writes
   wire wr_a = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_A_LATCH;
   wire wr_b = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_B_LATCH;
   wire wr_c = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_C_LATCH;
   wire wr_da = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_A_DIRECTION;
   wire wr_db = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_B_DIRECTION;
   wire wr_dc = cpu_wr_i && cpu_addr_i == PPK_OFF_PORT_C_DIRECTION;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dir_a_reg <= PPK_RST_DIRECTION;
         dir_b_reg <= PPK_RST_DIRECTION;
         dir_c_reg <= PPK_RST_DIRECTION;
         latch_a_reg <= PPK_RST_LATCH;
         latch_b_reg <= PPK_RST_LATCH;
         latch_c_reg <= PPK_RST_LATCH;
      end else begin
         if (wr_a) latch_a_reg <= cpu_wdata_i;
         if (wr_b) latch_b_reg <= cpu_wdata_i;
         if (wr_c) latch_c_reg <= cpu_wdata_i;
         if (wr_da) dir_a_reg <= cpu_wdata_i;
         if (wr_db) dir_b_reg <= cpu_wdata_i;
         if (wr_dc) dir_c_reg <= cpu_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: output pins read latch, input pins read the pin
   wire [7:0] rd_a = (dir_a_reg & latch_a_reg) | (~dir_a_reg & sa);
   wire [7:0] rd_b = (dir_b_reg & latch_b_reg) | (~dir_b_reg & sb);
   wire [7:0] rd_c = (dir_c_reg & latch_c_reg) | (~dir_c_reg & sc);
   wire [7:0] pd_owned = (sci_enable_i ? PPK_PD_SCI_MASK : 8'h00) | (spi_enable_i ? PPK_PD_SPI_MASK : 8'h00);
   wire [7:0] rd_d = sd & PPK_PD_PRESENT_MASK & ~pd_owned;
   logic [7:0] rd_mux;

   always_comb begin
      case (cpu_addr_i)
         PPK_OFF_PORT_A_LATCH: rd_mux = rd_a;
         PPK_OFF_PORT_B_LATCH: rd_mux = rd_b;
         PPK_OFF_PORT_C_LATCH: rd_mux = rd_c;
         PPK_OFF_PORT_D_INPUTS: rd_mux = rd_d;
         PPK_OFF_PORT_A_DIRECTION: rd_mux = dir_a_reg;
         PPK_OFF_PORT_B_DIRECTION: rd_mux = dir_b_reg;
         PPK_OFF_PORT_C_DIRECTION: rd_mux = dir_c_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (cpu_rd_i) begin
         rdata_reg <= rd_mux;
      end
   end
   assign cpu_rdata_o = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // tone divider; a full period every 2*TONE_DIV clocks
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tone_cnt_reg <= 32'h00000000;
         tone_reg <= 1'b0;
      end else if (tone_cnt_reg == 32'(TONE_DIV - 1)) begin
         tone_cnt_reg <= 32'h00000000;
         tone_reg <= ~tone_reg;
      end else begin
         tone_cnt_reg <= tone_cnt_reg + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers; enables are active low
   wire [7:0] tone_sel = TONE_OPTION ? (PPK_TONE_MASK & latch_a_reg & dir_a_reg) : 8'h00;
   wire [7:0] a_level = (latch_a_reg & ~tone_sel) | (tone_sel & {8{tone_reg}});
   // open drain: tone pins only drive high, a low lets the wire-or pull down
   wire [7:0] a_od = (TONE_OPTION && OPEN_DRAIN_OPTION) ? (PPK_TONE_MASK & dir_a_reg) : 8'h00;
   assign port_a_pin_o = a_level;
   assign port_a_pin_oe_n_o = ~(dir_a_reg & ~(a_od & ~a_level));
   assign port_b_pin_o = latch_b_reg;
   assign port_b_pin_oe_n_o = ~dir_b_reg;
   assign port_c_pin_o = latch_c_reg;
   assign port_c_pin_oe_n_o = ~dir_c_reg;
   assign port_b_pullup_o = KEYBOARD_OPTION ? ~dir_b_reg : 8'h00;

   // port d lines feed the serial blocks and the read path; never driven here
   assign sci_rx_o = sd[PPK_PD_RXD_BIT];
   assign spi_miso_o = sd[PPK_PD_MISO_BIT];
   assign spi_mosi_o = sd[PPK_PD_MOSI_BIT];
   assign spi_sck_o = sd[PPK_PD_SCK_BIT];
   assign spi_ss_n_o = sd[PPK_PD_SS_BIT];

   ////////////////////////////////////////////////////////////////////////
   // combined interrupt line, active low sources
   wire [7:0] kb_src = KEYBOARD_OPTION ? (~sb & ~dir_b_reg) : 8'h00;
   wire any_low = ~irq_sync | (|kb_src);
   assign int_line_high_o = ~any_low;

   // edge detector rearms only after every source is high
   wire fall_evt = (irq_state_reg == PPK_IRQ_ARMED) && any_low;
   always_comb begin
      case (irq_state_reg)
         PPK_IRQ_IDLE: irq_state_next = any_low ? PPK_IRQ_IDLE : PPK_IRQ_ARMED;
         PPK_IRQ_ARMED: irq_state_next = any_low ? PPK_IRQ_IDLE : PPK_IRQ_ARMED;
         default: irq_state_next = PPK_IRQ_IDLE;
      endcase
   end

   // level mode requests while any source is low
   wire set_req = LEVEL_SENSE ? any_low : fall_evt;
   // service needs instruction end and a clear mask; a set wins over ack
   wire serve = pending_reg && instr_end_i && !int_mask_i;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_state_reg <= PPK_IRQ_IDLE;
         pending_reg <= 1'b0;
      end else begin
         irq_state_reg <= irq_state_next;
         if (set_req) begin
            pending_reg <= 1'b1;
         end else if (int_ack_i) begin
            pending_reg <= 1'b0;
         end
      end
   end
   assign ext_int_req_o = serve;

   ////////////////////////////////////////////////////////////////////////
   a_dir_reset: assert property (@(posedge sys_clk_i) rst_i |=> (dir_a_reg == 8'h00 && dir_b_reg == 8'h00 && dir_c_reg == 8'h00)) else $error("direction not cleared by reset");
   a_latch_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (cpu_wr_i && cpu_addr_i == 8'h00) |=> latch_a_reg == $past(cpu_wdata_i)) else $error("latch a not loaded");
   a_out_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port_c_pin_oe_n_o == ~dir_c_reg && port_c_pin_o == latch_c_reg) else $error("port c drive wrong");
   a_read_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (cpu_rd_i && cpu_addr_i == 8'h02 && dir_c_reg == 8'hFF && !cpu_wr_i) |=> cpu_rdata_o == latch_c_reg) else $error("output read not latch");
   a_dir_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (cpu_wr_i && cpu_addr_i == 8'h05) ##1 (cpu_rd_i && !cpu_wr_i && cpu_addr_i == 8'h05) |=> cpu_rdata_o == $past(cpu_wdata_i, 2)) else $error("direction readback wrong");
   a_pd_bit6: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(cpu_rd_i) |=> cpu_rdata_o[6] == 1'b0 || $past(cpu_addr_i) != 8'h03) else $error("port d bit 6 set");
   a_pullup_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port_b_pullup_o & dir_b_reg) == 8'h00) else $error("pullup on output pin");
   a_mask_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      int_mask_i |-> !ext_int_req_o) else $error("request while masked");
   a_edge_once: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!LEVEL_SENSE && set_req) |=> !set_req) else $error("edge mode repeated request");
endmodule
`default_nettype wire

// [test/ppk_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
// pads, loads and switches on one 8-bit port
module ppk_pin_model (
   input wire logic [7:0] drv_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] pullup_i,
   input wire logic [7:0] ext_v_i,
   input wire logic [7:0] ext_en_i,
   output logic [7:0] level_o
);
   // released and floating: inverse of last drive, so no stale value passes
   assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_v_i)
      | (oe_n_i & ~ext_en_i & pullup_i)
      | (oe_n_i & ~ext_en_i & ~pullup_i & ~drv_i);
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr = 1'b0, rd_s = 1'b0, msk = 1'b1, iend = 1'b0, ack = 1'b0, irq_n = 1'b1, sci = 1'b0, spi = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, pd = 8'hFF, keys = 8'h00, rdata;
   logic [7:0] pa_ext = 8'h3C, pc_v = 8'h00, pc_en = 8'h00;
   logic [7:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pb_pu, pc_i, pc_o, pc_oe;
   logic req, lh, s_rx, s_mi, s_mo, s_ck, s_ss, p7;
   int n_errors = 0, comparisons = 0, cycles = 0, tg;
   always #25 sys_clk_i = ~sys_clk_i;
   ppk_ports #(.TONE_DIV(4)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_addr_i(addr), .cpu_wr_i(wr),
      .cpu_rd_i(rd_s), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .int_mask_i(msk), .instr_end_i(iend),
      .int_ack_i(ack), .ext_int_req_o(req), .int_line_high_o(lh), .port_a_pin_i(pa_i), .port_a_pin_o(pa_o),
      .port_a_pin_oe_n_o(pa_oe), .port_b_pin_i(pb_i), .port_b_pin_o(pb_o), .port_b_pin_oe_n_o(pb_oe),
      .port_b_pullup_o(pb_pu), .port_c_pin_i(pc_i), .port_c_pin_o(pc_o), .port_c_pin_oe_n_o(pc_oe),
      .port_d_pin_i(pd), .irq_pin_n_i(irq_n), .sci_enable_i(sci), .spi_enable_i(spi), .sci_rx_o(s_rx),
      .spi_miso_o(s_mi), .spi_mosi_o(s_mo), .spi_sck_o(s_ck), .spi_ss_n_o(s_ss));
   ppk_pin_model pa_u (.drv_i(pa_o), .oe_n_i(pa_oe), .pullup_i(8'h00), .ext_v_i(pa_ext), .ext_en_i(8'hFF),
      .level_o(pa_i));
   // closed switch pulls the line to ground
   ppk_pin_model pb_u (.drv_i(pb_o), .oe_n_i(pb_oe), .pullup_i(pb_pu), .ext_v_i(8'h00), .ext_en_i(keys),
      .level_o(pb_i));
   ppk_pin_model pc_u (.drv_i(pc_o), .oe_n_i(pc_oe), .pullup_i(8'h00), .ext_v_i(pc_v), .ext_en_i(pc_en),
      .level_o(pc_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk_i);
      rd_s <= 1'b0;
      #1;
      chk(n, rdata, e);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles >= 3000) begin
         n_errors++;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      cyc(4);
      chk("oe_a", pa_oe, 8'hFF);
      chk("pullup", pb_pu, 8'hFF);
      rdc(8'h04, 8'h00, "dir_a");
      rdc(8'h05, 8'h00, "dir_b");
      rdc(8'h06, 8'h00, "dir_c");
      // port a mixed directions
      wrr(8'h04, 8'h0F);
      wrr(8'h00, 8'hA5);
      cyc(5);
      chk("oe_a", pa_oe, 8'hF0);
      chk("drv_a", {4'h0, pa_o[3:0]}, 8'h05);
      rdc(8'h00, 8'h35, "mix_a");
      rdc(8'h04, 8'h0F, "dir_a");
      // upper bits with latch one carry the tone, latch zero stays low
      wrr(8'h04, 8'hFF);
      cyc(2);
      tg = 0;
      p7 = pa_o[7];
      repeat (20) begin
         cyc(1);
         if (pa_o[7] !== p7) tg++;
         p7 = pa_o[7];
         chk("tone_off", {7'h00, pa_o[6]}, 8'h00);
      end
      chk("tone", {7'h00, tg > 2}, 8'h01);
      // latch loads while still input
      pc_v <= 8'h5A;
      pc_en <= 8'hFF;
      wrr(8'h02, 8'h81);
      rdc(8'h02, 8'h5A, "in_c");
      wrr(8'h06, 8'hFF);
      cyc(2);
      chk("drv_c", pc_o, 8'h81);
      chk("oe_c", pc_oe, 8'h00);
      rdc(8'h02, 8'h81, "rd_c");
      rdc(8'h07, 8'h00, "unmapped");
      // port d with serial blocks off then on
      pd <= 8'h15;
      cyc(4);
      rdc(8'h03, 8'h15, "pd_in");
      chk("pd_ser", {3'h0, s_rx, s_mi, s_mo, s_ck, s_ss}, 8'h1A);
      pd <= 8'hFF;
      cyc(4);
      rdc(8'h03, 8'hBF, "pd_b6");
      sci <= 1'b1;
      rdc(8'h03, 8'hBC, "pd_sci");
      spi <= 1'b1;
      rdc(8'h03, 8'h80, "pd_spi");
      // keyboard press while masked
      keys <= 8'h01;
      iend <= 1'b1;
      cyc(6);
      chk("line", {7'h00, lh}, 8'h00);
      chk("masked", {7'h00, req}, 8'h00);
      msk <= 1'b0;
      cyc(1);
      chk("req", {7'h00, req}, 8'h01);
      @(posedge sys_clk_i);
      ack <= 1'b1;
      @(posedge sys_clk_i);
      ack <= 1'b0;
      cyc(6);
      chk("held", {7'h00, req}, 8'h00);
      keys <= 8'h00;
      cyc(6);
      irq_n <= 1'b0;
      cyc(6);
      chk("irq_pin", {7'h00, req}, 8'h01);
      @(posedge sys_clk_i);
      ack <= 1'b1;
      irq_n <= 1'b1;
      @(posedge sys_clk_i);
      ack <= 1'b0;
      // output pin masks its key; latch high first before reenabling
      wrr(8'h01, 8'hFF);
      wrr(8'h05, 8'h01);
      keys <= 8'h01;
      cyc(6);
      chk("pu_off", pb_pu, 8'hFE);
      chk("line_out", {7'h00, lh}, 8'h01);
      keys <= 8'h00;
      wrr(8'h05, 8'h00);
      cyc(6);
      chk("no_false", {7'h00, req}, 8'h00);
      test_done;
   end
endmodule
`default_nettype wire
